/* File: logic/bdd_bridge.sv */
// full-bridge steering and dead-band stage of the complementary waveform unit
// How it works
// - async input adds at most one clock
// - direction written anytime, taken at rising input
// - steady outputs A, C switch at rising input
// - B, D held off for dead band
// - rising dead band on pulses after a direction change until one outlasts it; falling dead band on every pulse that reaches the on state
`timescale 1ns/10ps
module bdd_bridge
  import bdd_pkg::*;
#(
  parameter int DBW = bdd_pkg::BDD_DB_WIDTH
) (
  input wire logic core_clk, // generator clock
  input wire logic rst_n, // async reset, low
  input wire logic modulation_input, // modulating data
  input wire logic direction, // 0 forward, 1 reverse
  input wire logic [DBW-1:0] rising_deadband_count, // rising delay, cycles
  input wire logic [DBW-1:0] falling_deadband_count, // falling delay, cycles
  output logic bridge_out_a, // steady, forward
  output logic bridge_out_b, // modulated, reverse
  output logic bridge_out_c, // steady, reverse
  output logic bridge_out_d // modulated, forward
);
  import bdd_pkg::*;

  // ==========================================================
  // input edge detect
  // ==========================================================
  // one register stage: the only source of timing uncertainty, bounded by one clock
  logic mod_reg;
  logic dir_reg, dir_next;
  logic first_reg, first_next;
  logic a_reg, a_next, b_reg, b_next, c_reg, c_next, d_reg, d_next;
  bdd_state_t st_reg, st_next;
  logic rise, fall, ld, done;
  logic [DBW-1:0] ld_cnt;

  assign rise = modulation_input && !mod_reg;
  assign fall = !modulation_input && mod_reg;

  // ==========================================================
  // dead-band timer
  // ==========================================================
  bdd_delay #(.W(DBW)) u_delay (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(ld),
    .count(ld_cnt),
    .done(done)
  );

  // ==========================================================
  // steering state machine
  // ==========================================================
  always_comb begin
    dir_next = dir_reg;
    first_next = first_reg;
    st_next = st_reg;
    a_next = a_reg;
    c_next = c_reg;
    b_next = 1'b0;
    d_next = 1'b0;
    ld = 1'b0;
    ld_cnt = rising_deadband_count;
    case (st_reg)
      bdd_idle: begin
        if (rise) begin
          if (direction != dir_reg) begin
            dir_next = direction;
            first_next = 1'b1;
          end
          a_next = !direction;
          c_next = direction;
          if (direction != dir_reg || first_reg) begin
            // zero count falls through to on next cycle
            ld = 1'b1;
            st_next = bdd_rise_wait;
          end else begin
            st_next = bdd_on;
            b_next = direction;
            d_next = !direction;
          end
        end
      end
      bdd_rise_wait: begin
        if (!modulation_input) begin
          st_next = bdd_idle;
        end else if (done) begin
          st_next = bdd_on;
          first_next = 1'b0;
          b_next = dir_reg;
          d_next = !dir_reg;
        end
      end
      bdd_on: begin
        b_next = dir_reg;
        d_next = !dir_reg;
        if (fall) begin
          b_next = 1'b0;
          d_next = 1'b0;
          ld = 1'b1;
          ld_cnt = falling_deadband_count;
          st_next = bdd_fall_wait;
        end
      end
      bdd_fall_wait: begin
        // off-time guard; a new rise during it is ignored and lost
        if (done) begin
          st_next = bdd_idle;
        end
      end
      default: begin
        st_next = bdd_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_reg <= 1'b0;
      dir_reg <= BDD_DIR_RESET;
      first_reg <= 1'b0;
      st_reg <= bdd_idle;
      a_reg <= BDD_OUT_RESET;
      b_reg <= BDD_OUT_RESET;
      c_reg <= BDD_OUT_RESET;
      d_reg <= BDD_OUT_RESET;
    end else begin
      mod_reg <= modulation_input;
      dir_reg <= dir_next;
      first_reg <= first_next;
      st_reg <= st_next;
      a_reg <= a_next;
      b_reg <= b_next;
      c_reg <= c_next;
      d_reg <= d_next;
    end
  end

  assign bridge_out_a = a_reg;
  assign bridge_out_b = b_reg;
  assign bridge_out_c = c_reg;
  assign bridge_out_d = d_reg;
endmodule : bdd_bridge

/* File: logic/bdd_pkg.sv */
// package: constants and types for the bridge direction dead-band stage
package bdd_pkg;
  localparam int BDD_DB_WIDTH = 6;
  localparam logic [BDD_DB_WIDTH-1:0] BDD_DB_RESET = 6'h00;
  localparam logic BDD_DIR_RESET = 1'b0;
  localparam logic BDD_OUT_RESET = 1'b0;
  localparam int BDD_SYNC_STAGES = 1;
  typedef enum logic [1:0] {bdd_idle, bdd_rise_wait, bdd_on, bdd_fall_wait} bdd_state_t;
endpackage : bdd_pkg

/* File: logic/bdd_delay.sv */
// dead-band down counter
`timescale 1ns/10ps
module bdd_delay #(
  parameter int W = 6
) (
  input wire logic core_clk, // clock
  input wire logic rst_n, // async reset, low
  input wire logic load, // start counting
  input wire logic [W-1:0] count, // cycles to wait
  output logic done // counter at zero
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == '0) && !load;
endmodule : bdd_delay

/* File: verif/bdd_mod_src.sv */
// modulation source model feeding the bridge stage
`timescale 1ns/10ps
module bdd_mod_src (
  input wire logic core_clk, // clock
  output logic modulation_input // pulse out
);
  initial modulation_input = 1'b0;
  // low gap must outlast the fall guard or the rise is lost
  task automatic pulse(input int hi, input int lo);
    modulation_input <= 1'b1;
    repeat (hi) @(posedge core_clk);
    modulation_input <= 1'b0;
    repeat (lo) @(posedge core_clk);
  endtask : pulse
endmodule : bdd_mod_src

/* File: verif/bdd_bridge_sva.sv */
// checker: relations between bridge outputs
`timescale 1ns/10ps
module bdd_chk (
  input wire logic core_clk, // clock
  input wire logic rst_n, // reset
  input wire logic modulation_input, // data
  input wire logic bridge_out_a, // a
  input wire logic bridge_out_b, // b
  input wire logic bridge_out_c, // c
  input wire logic bridge_out_d // d
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_steady_excl: assert property (!(bridge_out_a && bridge_out_c)) else $error("a and c");
  a_fwd_pair: assert property (bridge_out_d |-> bridge_out_a) else $error("d no a");
  a_rev_pair: assert property (bridge_out_b |-> bridge_out_c) else $error("b no c");
  a_fall_drop: assert property ((bridge_out_b || bridge_out_d) && !modulation_input
    |-> ##[1:2] !(bridge_out_b || bridge_out_d)) else $error("late drop");
  a_rise_cause: assert property ($rose(bridge_out_b || bridge_out_d) |-> $past(modulation_input))
    else $error("no cause");
  a_change_gap: assert property ($changed(bridge_out_c) |-> !(bridge_out_b || bridge_out_d))
    else $error("no gap");
  cover property ($rose(bridge_out_c));
  cover property ($fell(bridge_out_c));
  cover property ($rose(bridge_out_d));
endmodule : bdd_chk
bind bdd_bridge bdd_chk u_chk (.core_clk, .rst_n, .modulation_input, .bridge_out_a, .bridge_out_b,
  .bridge_out_c, .bridge_out_d);

/* File: verif/bdd_bridge_tb.sv */
// testbench: direction steering and dead-band timing
`timescale 1ns/10ps
module bdd_bridge_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, dir = 1'b0, a, b, c, d, mi;
  logic [5:0] rc = 6'h00;
  logic [5:0] fc = 6'h02;
  int error_cnt = 0, n_compared = 0;
  // {direction, rising count, expected cycles to modulated output}
  logic [14:0] rows [6] = '{15'h0302, 15'h0002, 15'h4003, 15'h4502, 15'h070A, 15'h4104};
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  bdd_mod_src src (.core_clk(core_clk), .modulation_input(mi));
  bdd_bridge uut (.core_clk(core_clk), .rst_n(rst_n), .modulation_input(mi), .direction(dir),
    .rising_deadband_count(rc), .falling_deadband_count(fc), .bridge_out_a(a),
    .bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d));
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", n, e, s);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // cycles from input rise to modulated output; one clock slack for input sync
  task automatic run(input logic nd, input logic [7:0] e);
    logic [7:0] k;
    k = 8'h00;
    @(posedge core_clk);
    dir <= nd;
    fork
      src.pulse(14, 6);
      begin
        while (k < 8'h0F && !(nd ? b : d)) begin
          @(negedge core_clk);
          k++;
        end
      end
    join
    check("delay", e, k - (k == e + 8'h01));
    check("steady", {7'h00, nd}, {a == nd, c});
    check("mod off", 8'h00, {b, d});
  endtask : run
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    check("reset", 8'h00, {a, b, c, d});
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rc <= rows[i][13:8];
      run(rows[i][14], rows[i][7:0]);
    end
    fork
      src.pulse(14, 6);
      begin
        repeat (8) @(posedge core_clk);
        dir <= 1'b0;
      end
    join
    check("held c", 8'h01, c);
    run(1'b0, 8'h04);
    // zero fall guard: a two-cycle low gap must not lose the next rise
    fc <= 6'h00;
    src.pulse(14, 1);
    run(1'b0, 8'h02);
    rst_n <= 1'b0;
    @(negedge core_clk);
    check("reset", 8'h00, {a, b, c, d});
    tally_and_finish();
  end
  initial begin
    #200000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : bdd_bridge_tb
